// file: verilog/i2cms_map.vh
// Purpose: Register map, field positions and bit timing counts of the
//          two-wire bus master sequencer.
// Assumes: Word index on the register bus, one register per 32-bit word.
// Notes:   Timing tables pack four reduction steps, one byte each.
`ifndef I2CMS_MAP_VH
`define I2CMS_MAP_VH

// ****************************************************************
// Register word indices.
// ****************************************************************
`define I2CMS_IDX_RXB 3'h0
`define I2CMS_IDX_SA 3'h1
`define I2CMS_IDX_TXB 3'h2
`define I2CMS_IDX_CTL 3'h3
`define I2CMS_IDX_MOD 3'h4
`define I2CMS_IDX_STAT 3'h5

// ****************************************************************
// Field positions and reset values.
// ****************************************************************
`define I2CMS_CTL_START 0
`define I2CMS_CTL_STOP 1
`define I2CMS_CTL_RESTART 2
`define I2CMS_CTL_ACKDRV 7
`define I2CMS_MOD_EN 0
`define I2CMS_MOD_FAST 1
`define I2CMS_MOD_DW_LO 2
`define I2CMS_MOD_DW_HI 3
`define I2CMS_MOD_SYN 4
`define I2CMS_SA_DIR 0
`define I2CMS_REG_RESET 8'h00

// ****************************************************************
// System clocks per high-speed clock period (25 MHz / 6).
// ****************************************************************
`define I2CMS_HS_DIV 3'h6

// ****************************************************************
// Phase lengths in high-speed clock periods, byte n = reduction n.
// ****************************************************************
`define I2CMS_SM_HOLD_DAT 8'h04
`define I2CMS_SM_HIGH 32'h18161412
`define I2CMS_SM_LOW 32'h1c1a1816
`define I2CMS_FM_HOLD_DAT 8'h02
`define I2CMS_FM_HIGH 32'h05050404
`define I2CMS_FM_LOW 32'h08070706
`define I2CMS_FM_SU_DAT 32'h06050504

`endif

// file: verilog/i2cms_sync.v
// Purpose: Two-stage synchroniser for a level from outside the clock.
// Assumes: Input may change at any time relative to i_clk.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/1ps

// ****************************************************************
// Synchroniser module.
// ****************************************************************
module i2cms_sync
#(
  parameter RESET_VAL = 1'b1
)
(
  input wire i_clk,
  input wire i_reset_n,
  input wire i_async,
  output reg o_sync
);

  // First stage, read by the second stage alone.
  reg meta;

  // Two flops in a row settle any metastable sample.
  always @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      meta <= RESET_VAL;
      o_sync <= RESET_VAL;
    end
    else
    begin
      meta <= i_async;
      o_sync <= meta;
    end
  end

endmodule // i2cms_sync

// file: verilog/i2cms_master.v
// Purpose: Single-master two-wire bus sequencer with an Avalon-MM slave.
// Assumes: 25 MHz i_clk; pins are open drain with external pull-ups.
// Notes:   Bit phases are timed in high-speed clock ticks from a divider.
`timescale 1ns/1ps
`include "i2cms_map.vh"

// Functional notes
// - Start from idle gives start then address.
// - Restart plus start gives repeated start.
// - Address and direction go MSB first, ack kept.
// - Transmit byte goes MSB first, ack kept.
// - After ack, hold in wait state.
// - Line bits land in receive register.
// - Receive samples at high clock, drives ack.
// - Receive byte stored after ack; ack kept.
// - Wait entry raises interrupt request.
// - Start in wait moves next byte.
// - Stop or restart in wait chosen.
// - Stop waveform then interrupt request.
// - Mismatch sets error, byte continues.
// - Control write clears transmit error.
// - Standard mode phase counts per reduction.
// - Fast mode phase counts per reduction.
// - Lines only pulled low or released.
// - Address bit zero selects direction.
// - Mode bit selects standard or fast.
// - Two bits select speed reduction.
// - Disabled block ignores start, clears registers.
module i2cms_master
(
  input wire i_clk,
  input wire i_reset_n,
  input wire [2:0] i_avs_address,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire [31:0] i_avs_writedata,
  input wire [3:0] i_avs_byteenable,
  output reg [31:0] o_avs_readdata,
  output wire o_avs_waitrequest,
  input wire i_sda,
  output wire o_sda_out,
  output reg o_sda_oe,
  input wire i_scl,
  output wire o_scl_out,
  output reg o_scl_oe,
  output reg o_controller_interrupt
);

  // ****************************************************************
  // Sequencer states.
  // ****************************************************************
  localparam S_IDLE = 4'h0;
  localparam S_ST_SU = 4'h1;
  localparam S_ST_HD = 4'h2;
  localparam S_B_HD = 4'h3;
  localparam S_B_SU = 4'h4;
  localparam S_B_HI = 4'h5;
  localparam S_WAIT = 4'h6;
  localparam S_SP_SU = 4'h7;
  localparam S_SP_HI = 4'h8;
  localparam S_SP_BUF = 4'h9;
  localparam S_RS_LO = 4'ha;

  reg rst_meta; // First reset release stage.
  reg rst_n; // Synchronised reset used by all logic.
  wire sda_s; // Synchronised data line.
  wire scl_s; // Synchronised clock line.
  reg [2:0] div_cnt; // High-speed clock divider.
  reg hs_tick; // One-cycle high-speed clock enable.
  reg [7:0] target_address_reg; // Address and direction.
  reg [7:0] transmit_byte_reg; // Byte to send.
  reg [7:0] receive_byte_reg; // Byte seen on the line.
  reg [7:0] mode_reg; // Enable, speed and reduction.
  reg start_request_bit; // Communication active.
  reg ack_drive_value; // Ack level sent after reception.
  reg ack_received_bit; // Last ack on the line.
  reg transmit_error_flag; // Sent bit differed from line.
  reg bus_busy_flag; // Between start and stop.
  reg [3:0] state; // Sequencer state.
  reg [7:0] cnt; // Remaining ticks of the phase.
  reg [8:0] shreg; // Outgoing bits, ack bit last.
  reg [8:0] rx_shift; // Incoming bits, ack bit last.
  reg [3:0] bitcnt; // Bits done in the byte.
  reg rx_phase; // Current byte is read from the slave.
  reg dir_rd; // Direction latched at the address.
  reg hold_low; // Level held during data hold time.
  reg rd_ack; // Read answer ready.
  reg sda_pull; // Combinational data line pull.
  reg scl_pull; // Combinational clock line pull.
  wire en; // Block enable.
  wire [1:0] dw; // Speed reduction code.
  wire wr; // Register write strobe.
  wire wr_ctl; // Control register write.
  wire phase_ok; // Phase may count down.
  wire done; // Current phase finished.
  wire drove_bit; // This bit position was ours.

  // ****************************************************************
  // Reset release and pin synchronisers.
  // ****************************************************************

  // Reset asserts at once and releases after two clock edges.
  always @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // Data line into the clock domain.
  i2cms_sync #(.RESET_VAL(1'b1)) u_sync_sda
  (
    .i_clk(i_clk),
    .i_reset_n(rst_n),
    .i_async(i_sda),
    .o_sync(sda_s)
  );

  // Clock line into the clock domain.
  i2cms_sync #(.RESET_VAL(1'b1)) u_sync_scl
  (
    .i_clk(i_clk),
    .i_reset_n(rst_n),
    .i_async(i_scl),
    .o_sync(scl_s)
  );

  // ****************************************************************
  // High-speed clock enable.
  // ****************************************************************

  // Divider gives one enable pulse per high-speed period.
  always @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div_cnt <= 3'h0;
      hs_tick <= 1'b0;
    end
    else if (div_cnt == `I2CMS_HS_DIV - 3'h1)
    begin
      div_cnt <= 3'h0;
      hs_tick <= 1'b1;
    end
    else
    begin
      div_cnt <= div_cnt + 3'h1;
      hs_tick <= 1'b0;
    end
  end

  // ****************************************************************
  // Phase lengths.
  // ****************************************************************
  assign en = mode_reg[`I2CMS_MOD_EN];
  assign dw = mode_reg[`I2CMS_MOD_DW_HI:`I2CMS_MOD_DW_LO];

  // Length of a state in high-speed periods for the current mode.
  function [7:0] plen;
    input [3:0] st;
    input fast;
    input [1:0] red;
    reg [7:0] hi;
    reg [7:0] lo;
    reg [7:0] hd;
    reg [7:0] su;
    reg [31:0] hiw; // High table moved to the selected byte.
    reg [31:0] low; // Low table moved to the selected byte.
    reg [31:0] suw; // Fast setup table moved to the selected byte.
    begin
      // Shift the packed table, then keep the lowest byte on purpose.
      hiw = (fast ? `I2CMS_FM_HIGH : `I2CMS_SM_HIGH) >> {red, 3'h0};
      low = (fast ? `I2CMS_FM_LOW : `I2CMS_SM_LOW) >> {red, 3'h0};
      suw = `I2CMS_FM_SU_DAT >> {red, 3'h0};
      hi = hiw[7:0];
      lo = low[7:0];
      hd = fast ? `I2CMS_FM_HOLD_DAT : `I2CMS_SM_HOLD_DAT;
      su = fast ? suw[7:0] : hi;
      case (st)
        S_ST_SU: plen = lo; // Restart setup.
        S_ST_HD: plen = hi; // Start hold.
        S_B_HD: plen = hd; // Data hold after falling clock.
        S_B_SU: plen = su; // Data setup.
        S_B_HI: plen = hi; // Clock high.
        S_SP_SU: plen = su; // Data low before clock rises.
        S_SP_HI: plen = hi; // Stop setup.
        S_SP_BUF: plen = lo; // Bus free time.
        S_RS_LO: plen = su; // Release data before restart.
        default: plen = 8'h01;
      endcase
    end
  endfunction

  // Bit and stop clock-high phases wait for the line really to be high; start setup and hold do not.
  assign phase_ok = ~(state == S_B_HI || state == S_SP_HI) | scl_s;
  assign done = hs_tick & phase_ok & (cnt <= 8'h01);
  assign drove_bit = (bitcnt < 4'h8) ? ~rx_phase : rx_phase;
  assign wr = i_avs_write & i_avs_byteenable[0];
  assign wr_ctl = wr & (i_avs_address == `I2CMS_IDX_CTL);

  // ****************************************************************
  // Register bus.
  // ****************************************************************

  // Reads wait one cycle for the registered answer; writes do not.
  assign o_avs_waitrequest = i_avs_read & ~rd_ack;

  // Read data register; unmapped words read as zero.
  always @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_ack <= 1'b0;
      o_avs_readdata <= 32'h0;
    end
    else if (i_avs_read & ~rd_ack)
    begin
      rd_ack <= 1'b1;
      case (i_avs_address)
        `I2CMS_IDX_RXB: o_avs_readdata <= {24'h0, receive_byte_reg};
        `I2CMS_IDX_SA: o_avs_readdata <= {24'h0, target_address_reg};
        `I2CMS_IDX_TXB: o_avs_readdata <= {24'h0, transmit_byte_reg};
        `I2CMS_IDX_CTL: o_avs_readdata <= {24'h0, ack_drive_value,
          6'h00, start_request_bit};
        `I2CMS_IDX_MOD: o_avs_readdata <= {24'h0, mode_reg};
        `I2CMS_IDX_STAT: o_avs_readdata <= {29'h0, transmit_error_flag,
          ack_received_bit, bus_busy_flag};
        default: o_avs_readdata <= 32'h0;
      endcase
    end
    else
    begin
      rd_ack <= 1'b0;
    end
  end

  // Mode register stays writable while the block is disabled.
  always @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_reg <= `I2CMS_REG_RESET;
    end
    else if (wr && i_avs_address == `I2CMS_IDX_MOD)
    begin
      mode_reg <= {3'h0, i_avs_writedata[4:0]};
    end
  end

  // ****************************************************************
  // Sequencer and remaining registers.
  // ****************************************************************

  // Disable holds every other register except rx_shift and dir_rd at its reset value.
  always @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      target_address_reg <= `I2CMS_REG_RESET;
      transmit_byte_reg <= `I2CMS_REG_RESET;
      receive_byte_reg <= `I2CMS_REG_RESET;
      start_request_bit <= 1'b0;
      ack_drive_value <= 1'b0;
      ack_received_bit <= 1'b0;
      transmit_error_flag <= 1'b0;
      bus_busy_flag <= 1'b0;
      state <= S_IDLE;
      cnt <= 8'h00;
      shreg <= 9'h1ff;
      rx_shift <= 9'h000;
      bitcnt <= 4'h0;
      rx_phase <= 1'b0;
      dir_rd <= 1'b0;
      hold_low <= 1'b0;
      o_controller_interrupt <= 1'b0;
    end
    else if (!en)
    begin
      target_address_reg <= `I2CMS_REG_RESET;
      transmit_byte_reg <= `I2CMS_REG_RESET;
      receive_byte_reg <= `I2CMS_REG_RESET;
      start_request_bit <= 1'b0;
      ack_drive_value <= 1'b0;
      ack_received_bit <= 1'b0;
      transmit_error_flag <= 1'b0;
      bus_busy_flag <= 1'b0;
      state <= S_IDLE;
      cnt <= 8'h00;
      shreg <= 9'h1ff;
      bitcnt <= 4'h0;
      rx_phase <= 1'b0;
      hold_low <= 1'b0;
      o_controller_interrupt <= 1'b0;
    end
    else
    begin
      o_controller_interrupt <= 1'b0;
      if (cnt != 8'h00 && hs_tick && phase_ok)
      begin
        cnt <= cnt - 8'h01;
      end
      // Plain data registers.
      if (wr && i_avs_address == `I2CMS_IDX_SA)
      begin
        target_address_reg <= i_avs_writedata[7:0];
      end
      if (wr && i_avs_address == `I2CMS_IDX_TXB)
      begin
        transmit_byte_reg <= i_avs_writedata[7:0];
      end
      // Any control write clears the error and skips the phase step below that cycle.
      if (wr_ctl)
      begin
        transmit_error_flag <= 1'b0;
        ack_drive_value <= i_avs_writedata[`I2CMS_CTL_ACKDRV];
      end
      if (wr_ctl && i_avs_writedata[`I2CMS_CTL_STOP])
      begin
        // Stop request drops the start bit and ends after a wait.
        start_request_bit <= 1'b0;
        if (state == S_WAIT)
        begin
          state <= S_SP_SU;
          cnt <= plen(S_SP_SU, mode_reg[1], dw);
        end
      end
      else if (wr_ctl && i_avs_writedata[`I2CMS_CTL_RESTART] &&
        i_avs_writedata[`I2CMS_CTL_START] && start_request_bit)
      begin
        // Restart is only taken while communication is active.
        if (state == S_WAIT)
        begin
          state <= S_RS_LO;
          cnt <= plen(S_RS_LO, mode_reg[1], dw);
        end
      end
      else if (wr_ctl && i_avs_writedata[`I2CMS_CTL_START])
      begin
        start_request_bit <= 1'b1;
        if (state == S_IDLE && !start_request_bit)
        begin
          state <= S_ST_SU;
          cnt <= plen(S_ST_SU, mode_reg[1], dw);
        end
        else if (state == S_WAIT)
        begin
          // Next byte in the latched direction.
          state <= S_B_SU;
          cnt <= plen(S_B_SU, mode_reg[1], dw);
          rx_phase <= dir_rd;
          bitcnt <= 4'h0;
          // The ack level written with this request is the one sent.
          shreg <= dir_rd ?
            {8'hff, i_avs_writedata[`I2CMS_CTL_ACKDRV]} :
            {transmit_byte_reg, 1'b1};
        end
      end
      else if (wr_ctl)
      begin
        // Clearing the start bit aborts and releases both lines.
        start_request_bit <= 1'b0;
        state <= S_IDLE;
      end
      else if (done)
      begin
        case (state)
          S_ST_SU:
          begin
            state <= S_ST_HD;
            cnt <= plen(S_ST_HD, mode_reg[1], dw);
            bus_busy_flag <= 1'b1;
          end
          S_ST_HD:
          begin
            // Start done: address and direction follow.
            state <= S_B_HD;
            cnt <= plen(S_B_HD, mode_reg[1], dw);
            hold_low <= 1'b1;
            bitcnt <= 4'h0;
            rx_phase <= 1'b0;
            dir_rd <= target_address_reg[`I2CMS_SA_DIR];
            shreg <= {target_address_reg, 1'b1};
          end
          S_B_SU:
          begin
            state <= S_B_HI;
            cnt <= plen(S_B_HI, mode_reg[1], dw);
          end
          S_B_HI:
          begin
            // Sample the line level at the end of the high phase.
            rx_shift <= {rx_shift[7:0], sda_s};
            if (drove_bit && shreg[8] != sda_s)
            begin
              transmit_error_flag <= 1'b1;
            end
            if (bitcnt == 4'h8)
            begin
              ack_received_bit <= sda_s;
            end
            hold_low <= ~shreg[8];
            shreg <= {shreg[7:0], 1'b1};
            bitcnt <= bitcnt + 4'h1;
            state <= S_B_HD;
            cnt <= plen(S_B_HD, mode_reg[1], dw);
          end
          S_B_HD:
          begin
            if (bitcnt == 4'h9)
            begin
              // Byte and ack complete: wait for software.
              receive_byte_reg <= rx_shift[8:1];
              state <= S_WAIT;
              o_controller_interrupt <= 1'b1;
            end
            else
            begin
              state <= S_B_SU;
              cnt <= plen(S_B_SU, mode_reg[1], dw);
            end
          end
          S_RS_LO:
          begin
            state <= S_ST_SU;
            cnt <= plen(S_ST_SU, mode_reg[1], dw);
          end
          S_SP_SU:
          begin
            state <= S_SP_HI;
            cnt <= plen(S_SP_HI, mode_reg[1], dw);
          end
          S_SP_HI:
          begin
            state <= S_SP_BUF;
            cnt <= plen(S_SP_BUF, mode_reg[1], dw);
            bus_busy_flag <= 1'b0;
          end
          S_SP_BUF:
          begin
            state <= S_IDLE;
            o_controller_interrupt <= 1'b1;
          end
          default:
          begin
            state <= state;
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // Open-drain line drive.
  // ****************************************************************

  // Which line each state pulls low.
  always @*
  begin
    sda_pull = 1'b0;
    scl_pull = 1'b1;
    case (state)
      S_IDLE: scl_pull = 1'b0;
      S_ST_SU: scl_pull = 1'b0;
      S_ST_HD:
      begin
        sda_pull = 1'b1;
        scl_pull = 1'b0;
      end
      S_B_HD: sda_pull = hold_low;
      S_B_SU: sda_pull = ~shreg[8];
      S_B_HI:
      begin
        sda_pull = ~shreg[8];
        scl_pull = 1'b0;
      end
      S_SP_SU: sda_pull = 1'b1;
      S_SP_HI:
      begin
        sda_pull = 1'b1;
        scl_pull = 1'b0;
      end
      S_SP_BUF: scl_pull = 1'b0;
      default: sda_pull = 1'b0;
    endcase
  end

  // Pins only ever pull low; a high level is left to the pull-up.
  assign o_sda_out = 1'b0;
  assign o_scl_out = 1'b0;

  // Registered enables keep the pins free of glitches.
  always @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_sda_oe <= 1'b0;
      o_scl_oe <= 1'b0;
    end
    else
    begin
      o_sda_oe <= sda_pull;
      o_scl_oe <= scl_pull;
    end
  end

endmodule // i2cms_master

// file: verification/i2cms_assertions.sv
// Purpose: Port-level checks of the two-wire bus sequencer.
// Assumes: Bound to every instance of the sequencer top module.
// Notes:   Phase bounds of 8 clocks stay below the shortest fast-mode phase lengths.
`timescale 1ns/1ps

// ****************************************************************
// Checker module.
// ****************************************************************
module i2cms_checker
(
  input wire i_clk,
  input wire i_reset_n,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire o_avs_waitrequest,
  input wire o_sda_out,
  input wire o_sda_oe,
  input wire o_scl_out,
  input wire o_scl_oe,
  input wire o_controller_interrupt
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_reset_n);

  // Pins are only ever pulled low or released.
  open_drain_a: assert property (!o_sda_out && !o_scl_out)
    else $error("pin driven to a high level");
  // The interrupt request is a single-cycle pulse.
  irq_pulse_a: assert property (o_controller_interrupt |=>
    !o_controller_interrupt) else $error("interrupt longer than a cycle");
  // Interrupts come with the clock held low or the bus fully free.
  irq_state_a: assert property (o_controller_interrupt |->
    (o_scl_oe || !o_sda_oe)) else $error("interrupt in mid-bit");
  // A released clock stays released for a whole high phase.
  scl_high_a: assert property ($fell(o_scl_oe) |->
    !o_scl_oe [*8]) else $error("clock high phase too short");
  // A pulled clock stays low for a whole low phase.
  scl_low_a: assert property ($rose(o_scl_oe) |->
    o_scl_oe [*8]) else $error("clock low phase too short");
  // A start holds the clock high, then pulls it within bounds.
  start_hold_a: assert property ($rose(o_sda_oe) && !o_scl_oe |->
    !o_scl_oe [*8] ##[1:400] o_scl_oe) else $error("bad start hold");
  // A stop is followed by the interrupt after the bus free time.
  stop_irq_a: assert property ($fell(o_sda_oe) && !o_scl_oe |->
    ##[1:400] o_controller_interrupt) else $error("no stop interrupt");
  // Reads are answered after one wait cycle; writes never wait.
  bus_answer_a: assert property ((i_avs_read && o_avs_waitrequest) |=>
    !o_avs_waitrequest) else $error("read answer late");
  write_nowait_a: assert property (i_avs_write |-> !o_avs_waitrequest)
    else $error("write stalled");

  cover property ($fell(o_sda_oe) && !o_scl_oe);
  cover property (o_controller_interrupt && o_scl_oe);
  cover property (i_avs_read && o_avs_waitrequest);
endmodule // i2cms_checker

bind i2cms_master i2cms_checker i2cms_checker_i (.i_clk(i_clk),
  .i_reset_n(i_reset_n), .i_avs_read(i_avs_read),
  .i_avs_write(i_avs_write), .o_avs_waitrequest(o_avs_waitrequest),
  .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe), .o_scl_out(o_scl_out),
  .o_scl_oe(o_scl_oe), .o_controller_interrupt(o_controller_interrupt));

// file: verification/i2cms_slave_model.sv
// Purpose: Behavioural slave on the two-wire bus.
// Assumes: Lines carry pull-ups; the model only pulls data low.
// Notes:   Acks its own address and written bytes, sends one byte.
`timescale 1ns/1ps

// ****************************************************************
// Slave model.
// ****************************************************************
module i2cms_slave_model
#(
  parameter [6:0] ADDR = 7'h2a
)
(
  input wire i_scl,
  input wire i_sda,
  input wire [7:0] i_read_byte,
  output reg o_sda_pull,
  output reg [7:0] o_got
);
  reg [3:0] bitn = 4'h0; // Bits seen in the current byte.
  reg [7:0] sh = 8'h00; // Shifted-in byte.
  reg in_addr = 1'b0; // The byte being shifted is the address.
  reg matched = 1'b0; // Our address was seen.
  reg reading = 1'b0; // The master reads from us.

  initial
  begin
    o_sda_pull = 1'b0;
    o_got = 8'h00;
  end

  // A data fall with the clock high opens a frame.
  always @(negedge i_sda)
    if (i_scl)
    begin
      bitn = 4'h0;
      in_addr = 1'b1;
      reading = 1'b0;
      o_sda_pull = 1'b0;
    end

  // Each rising clock shifts in one line bit.
  always @(posedge i_scl)
    if (bitn < 4'h9)
    begin
      sh = {sh[6:0], i_sda};
      bitn = bitn + 4'h1;
    end

  // Each falling clock sets up the next bit we drive.
  always @(negedge i_scl)
    if (bitn == 4'h8)
    begin
      if (in_addr)
      begin
        matched = (sh[7:1] == ADDR);
        reading = matched & sh[0];
      end
      else if (!reading && matched)
        o_got = sh;
      o_sda_pull = matched & (in_addr | ~reading);
      in_addr = 1'b0;
    end
    else if (bitn == 4'h9)
    begin
      bitn = 4'h0;
      o_sda_pull = reading & ~i_read_byte[7];
    end
    else if (reading && bitn != 4'h0)
      o_sda_pull = ~i_read_byte[3'h7 - bitn[2:0]];
endmodule // i2cms_slave_model

// file: verification/i2c_master_sequencer_tb.sv
// Purpose: Self-checking bench for the two-wire bus sequencer.
// Assumes: Slave model at address 2a answering byte 9c.
// Notes:   Registers are reached over the Avalon-MM slave port.
`timescale 1ns/1ps
`include "i2cms_map.vh"

module i2c_master_sequencer_tb;
  reg i_clk = 1'b0;
  reg i_reset_n = 1'b0;
  reg [2:0] addr = 3'h0;
  reg rd = 1'b0;
  reg wr = 1'b0;
  reg jam = 1'b0; // Bench pull that forces a bit error.
  reg [31:0] wdata = 32'h0;
  reg [31:0] q; // Last read word.
  wire [31:0] rdata;
  wire waitreq, sda_oe, scl_oe, irq, slv_pull;
  wire [7:0] slv_got;
  wire scl = ~scl_oe; // Pulled-up clock line.
  wire sda = ~(sda_oe | slv_pull | jam); // Pulled-up data line.
  integer fail_count = 0;
  integer comparisons = 0;
  integer i;

  always #20 i_clk = ~i_clk;

  i2cms_master i2cms_master_i (.i_clk(i_clk), .i_reset_n(i_reset_n),
    .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wdata), .i_avs_byteenable(4'hf),
    .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq), .i_sda(sda),
    .o_sda_out(), .o_sda_oe(sda_oe), .i_scl(scl), .o_scl_out(),
    .o_scl_oe(scl_oe), .o_controller_interrupt(irq));
  i2cms_slave_model i2cms_slave_model_i (.i_scl(scl), .i_sda(sda),
    .i_read_byte(8'h9c), .o_sda_pull(slv_pull), .o_got(slv_got));

  task check(input [31:0] seen, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp)
      begin
        fail_count = fail_count + 1;
        $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask

  // One bus cycle, held until waitrequest is sampled low at a rising edge.
  task bus(input w, input [2:0] a, input [7:0] d);
    begin
      @(posedge i_clk);
      addr <= a;
      wdata <= {24'h0, d};
      wr <= w;
      rd <= ~w;
      @(posedge i_clk);
      while (waitreq)
        @(posedge i_clk);
      q = rdata;
      wr <= 1'b0;
      rd <= 1'b0;
    end
  endtask

  task rchk(input [2:0] a, input [7:0] exp);
    begin
      bus(1'b0, a, 8'h00);
      check(q, {24'h0, exp});
    end
  endtask

  // Waits a bounded time for the interrupt pulse.
  task wait_irq;
    begin
      i = 0;
      while (irq !== 1'b1 && i < 20000)
      begin
        @(negedge i_clk);
        i = i + 1;
      end
      check({31'h0, irq}, 32'h1);
    end
  endtask

  task t_disabled;
    begin
      for (i = 0; i < 8; i = i + 1)
        rchk(i[2:0], 8'h00);
      bus(1'b1, `I2CMS_IDX_SA, 8'h54);
      bus(1'b1, `I2CMS_IDX_CTL, 8'h01);
      repeat (60) @(posedge i_clk);
      check({31'h0, scl_oe | sda_oe}, 32'h0);
      rchk(`I2CMS_IDX_CTL, 8'h00);
      rchk(`I2CMS_IDX_SA, 8'h00);
    end
  endtask

  task t_write;
    begin
      bus(1'b1, `I2CMS_IDX_MOD, 8'h01);
      bus(1'b1, `I2CMS_IDX_SA, 8'h54);
      bus(1'b1, `I2CMS_IDX_TXB, 8'hc3);
      bus(1'b1, `I2CMS_IDX_CTL, 8'h01);
      wait_irq;
      rchk(`I2CMS_IDX_RXB, 8'h54);
      rchk(`I2CMS_IDX_STAT, 8'h01);
      repeat (300) @(posedge i_clk);
      check({31'h0, scl_oe}, 32'h1);
      bus(1'b1, `I2CMS_IDX_CTL, 8'h01);
      wait_irq;
      check({24'h0, slv_got}, 32'hc3);
      rchk(`I2CMS_IDX_RXB, 8'hc3);
      bus(1'b1, `I2CMS_IDX_CTL, 8'h02);
      wait_irq;
      rchk(`I2CMS_IDX_STAT, 8'h00);
      rchk(`I2CMS_IDX_CTL, 8'h00);
    end
  endtask

  task t_read;
    begin
      bus(1'b1, `I2CMS_IDX_MOD, 8'h0f);
      bus(1'b1, `I2CMS_IDX_SA, 8'h55);
      bus(1'b1, `I2CMS_IDX_CTL, 8'h01);
      wait_irq;
      bus(1'b1, `I2CMS_IDX_CTL, 8'h81);
      wait_irq;
      rchk(`I2CMS_IDX_RXB, 8'h9c);
      rchk(`I2CMS_IDX_STAT, 8'h03);
      bus(1'b1, `I2CMS_IDX_MOD, 8'h07);
      bus(1'b1, `I2CMS_IDX_CTL, 8'h05);
      wait_irq;
      rchk(`I2CMS_IDX_RXB, 8'h55);
      rchk(`I2CMS_IDX_STAT, 8'h01);
      bus(1'b1, `I2CMS_IDX_CTL, 8'h02);
      wait_irq;
    end
  endtask

  task t_nack;
    begin
      bus(1'b1, `I2CMS_IDX_MOD, 8'h09);
      bus(1'b1, `I2CMS_IDX_SA, 8'h20);
      bus(1'b1, `I2CMS_IDX_CTL, 8'h01);
      // Hold the line low across the only address bit that is a one.
      repeat (700) @(posedge i_clk);
      jam <= 1'b1;
      repeat (600) @(posedge i_clk);
      jam <= 1'b0;
      wait_irq;
      rchk(`I2CMS_IDX_STAT, 8'h07);
      rchk(`I2CMS_IDX_RXB, 8'h00);
      bus(1'b1, `I2CMS_IDX_CTL, 8'h02);
      wait_irq;
      rchk(`I2CMS_IDX_STAT, 8'h02);
      bus(1'b1, `I2CMS_IDX_MOD, 8'h00);
      rchk(`I2CMS_IDX_STAT, 8'h00);
    end
  endtask

  task tally_and_finish;
    begin
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask

  // Cuts a hang short well past the expected run length.
  initial
  begin
    repeat (60000) @(posedge i_clk);
    fail_count = fail_count + 1;
    tally_and_finish;
  end

  initial
  begin
    repeat (20) @(posedge i_clk);
    i_reset_n <= 1'b1;
    repeat (3) @(posedge i_clk);
    t_disabled;
    t_write;
    t_read;
    t_nack;
    tally_and_finish;
  end
endmodule // i2c_master_sequencer_tb
